/* rtl/tpss_core.sv */
// Power state control, touch status and alert logic behind the management bus
`timescale 1ns/1ps
module tpss_core #(
  parameter logic [6:0] DEV_ADDR = 7'h28
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Management bus pins, open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Sensing front end events and levels
  input wire logic [7:0] touch_now,
  input wire logic [7:0] active_en,
  input wire logic [7:0] irq_en,
  input wire logic [7:0] base_err,
  input wire logic [7:0] cal_err,
  input wire logic power_key_evt,
  input wire logic power_key_touch,
  input wire logic multi_block,
  input wire logic pattern_hit,
  input wire logic pattern_irq_en,
  // Alert and state outputs
  output logic alert_out_n,
  output tpss_pkg::tpss_pstate_t power_state,
  output logic [7:0] scan_mask,
  output logic [3:0] active_gain,
  output logic [3:0] standby_gain,
  output logic recal_req,
  output logic [7:0] release_evt
);
  import tpss_pkg::*;
  logic [7:0] reg_ptr, wr_data, rd_data;
  logic wr_stb;
  logic [7:0] ctrl_reg, ctrl_next, low_power_scan_en_reg, low_power_scan_en_next;
  logic [7:0] gstat_reg, gstat_next, tstat_reg, tstat_next;
  logic [7:0] tprev_reg, tprev_next, rel_reg, rel_next;
  logic [7:0] mask_reg, mask_next, mask_c, tm, new_touch;
  logic [3:0] again_reg, again_next, sgain_reg, sgain_next;
  logic boot_reg, boot_next, alert_n_reg, alert_n_next, recal_reg, recal_next;
  logic wr_ctrl, int_clr, pat_irq, irq_set, deep_nx;
  tpss_pstate_t ps_c, ps_reg;

  tpss_i2c_target #(
    .DEV_ADDR(DEV_ADDR)
  ) u_bus (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe(sda_oe),
    .reg_ptr(reg_ptr),
    .wr_stb(wr_stb),
    .wr_data(wr_data),
    .rd_data(rd_data)
  );

  // Read mux; unmapped pointers read as zero
  always_comb begin
    if (reg_ptr == TPSS_ADDR_CTRL) begin
      rd_data = ctrl_reg;
    end else if (reg_ptr == TPSS_ADDR_GSTAT) begin
      rd_data = gstat_reg;
    end else if (reg_ptr == TPSS_ADDR_TSTAT) begin
      rd_data = tstat_reg;
    end else if (reg_ptr == TPSS_ADDR_LOW_POWER_SCAN_EN) begin
      rd_data = low_power_scan_en_reg;
    end else begin
      rd_data = 8'h00;
    end
  end

  // Power state and scan set, from the current control bits
  always_comb begin
    if (ctrl_reg[TPSS_DEEP_BIT]) begin
      ps_c = TPSS_PS_DEEP;
    end else if (ctrl_reg[TPSS_MIX_BIT]) begin
      ps_c = TPSS_PS_COMBO;
    end else if (ctrl_reg[TPSS_LPS_BIT]) begin
      ps_c = TPSS_PS_STANDBY;
    end else begin
      ps_c = TPSS_PS_ACTIVE;
    end
    case (ps_c)
      TPSS_PS_STANDBY: mask_c = low_power_scan_en_reg;
      TPSS_PS_COMBO: mask_c = active_en | low_power_scan_en_reg;
      TPSS_PS_DEEP: mask_c = 8'h00;
      default: mask_c = active_en;
    endcase
  end

  assign tm = touch_now & mask_c;
  assign new_touch = tm & ~tprev_reg;
  assign wr_ctrl = wr_stb && reg_ptr == TPSS_ADDR_CTRL;
  assign int_clr = wr_ctrl && !wr_data[TPSS_IRQ_BIT];
  // Pattern interrupts fire once per rise of the status bit
  assign pat_irq = pattern_hit && !gstat_reg[TPSS_GS_PAT] && pattern_irq_en;
  // Disabled inputs and multi-touch blocking never reach the flag
  assign irq_set = (|(new_touch & irq_en)) | power_key_evt | boot_reg | pat_irq;
  assign deep_nx = ctrl_next[TPSS_DEEP_BIT];

  always_comb begin
    ctrl_next = ctrl_reg;
    low_power_scan_en_next = low_power_scan_en_reg;
    if (wr_ctrl) begin
      ctrl_next[7:1] = wr_data[7:1];
    end
    if (wr_stb && reg_ptr == TPSS_ADDR_LOW_POWER_SCAN_EN) begin
      low_power_scan_en_next = wr_data;
    end
    if (int_clr) begin
      ctrl_next[TPSS_IRQ_BIT] = 1'b0;
    end
    // Host writing one to the flag has no effect
    if (irq_set) begin
      ctrl_next[TPSS_IRQ_BIT] = 1'b1;
    end
    if (ctrl_next[TPSS_DEEP_BIT]) begin
      ctrl_next[TPSS_IRQ_BIT] = 1'b0;
    end
    alert_n_next = ~ctrl_next[TPSS_IRQ_BIT];
    recal_next = wr_ctrl && (wr_data[7:6] != ctrl_reg[7:6]
                 || wr_data[3:2] != ctrl_reg[3:2]);
  end

  always_comb begin
    boot_next = 1'b0;
    tprev_next = tm;
    // One release per input that drops out of scanning while touched
    rel_next = tprev_reg & ~mask_c;
    if (int_clr) begin
      tstat_next = tm;
    end else begin
      tstat_next = tstat_reg | tm;
    end
    gstat_next = TPSS_GSTAT_RST;
    gstat_next[TPSS_GS_BC] = |(base_err & mask_c);
    gstat_next[TPSS_GS_CAL] = |(cal_err & mask_c);
    gstat_next[TPSS_GS_MULTI_TOUCH_BLOCK] = multi_block;
    gstat_next[TPSS_GS_PWR] = (gstat_reg[TPSS_GS_PWR] && !(int_clr && !power_key_touch))
                              || power_key_evt;
    gstat_next[TPSS_GS_BOOT] = (gstat_reg[TPSS_GS_BOOT] && !int_clr) || boot_reg;
    gstat_next[TPSS_GS_PAT] = (gstat_reg[TPSS_GS_PAT] && !(int_clr && !pattern_hit))
                              || pattern_hit;
    if (deep_nx) begin
      tstat_next = TPSS_TSTAT_RST;
      gstat_next = TPSS_GSTAT_RST;
    end
    gstat_next[TPSS_GS_TOUCH] = |tstat_next;
  end

  always_comb begin
    mask_next = mask_c;
    again_next = 4'h1 << ctrl_reg[TPSS_GAIN_LSB +: 2];
    if (ctrl_reg[TPSS_MIX_BIT]) begin
      sgain_next = 4'h1 << ctrl_reg[TPSS_CGAIN_LSB +: 2];
    end else begin
      sgain_next = again_next;
    end
  end

  // Boot flag is a constant at reset and posts its event on the first edge after release
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= TPSS_CTRL_RST;
      low_power_scan_en_reg <= TPSS_LOW_POWER_SCAN_EN_RST;
      gstat_reg <= TPSS_GSTAT_RST;
      tstat_reg <= TPSS_TSTAT_RST;
      tprev_reg <= 8'h00;
      rel_reg <= 8'h00;
      mask_reg <= 8'h00;
      again_reg <= 4'h1;
      sgain_reg <= 4'h1;
      boot_reg <= 1'b1;
      alert_n_reg <= 1'b1;
      recal_reg <= 1'b0;
      ps_reg <= TPSS_PS_ACTIVE;
    end else begin
      ctrl_reg <= ctrl_next;
      low_power_scan_en_reg <= low_power_scan_en_next;
      gstat_reg <= gstat_next;
      tstat_reg <= tstat_next;
      tprev_reg <= tprev_next;
      rel_reg <= rel_next;
      mask_reg <= mask_next;
      again_reg <= again_next;
      sgain_reg <= sgain_next;
      boot_reg <= boot_next;
      alert_n_reg <= alert_n_next;
      recal_reg <= recal_next;
      ps_reg <= ps_c;
    end
  end

  assign sda_out = 1'b0;
  assign alert_out_n = alert_n_reg;
  assign power_state = ps_reg;
  assign scan_mask = mask_reg;
  assign active_gain = again_reg;
  assign standby_gain = sgain_reg;
  assign recal_req = recal_reg;
  assign release_evt = rel_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence clr_and_set_s;
    int_clr && irq_set && !deep_nx;
  endsequence

  sequence quiet_touch_s;
    !ctrl_reg[TPSS_IRQ_BIT] && (new_touch != 8'h00) && ((new_touch & irq_en) == 8'h00)
    && !power_key_evt && !boot_reg && !pat_irq;
  endsequence

  // Checks other than alert_level_a, deep_clear_a and touch_sum_a look one edge after the cause, where the registers have settled
  alert_level_a: assert property (alert_out_n == ~ctrl_reg[TPSS_IRQ_BIT])
    else $error("alert output disagrees with irq flag");

  state_prio_a: assert property (##1
    (ps_reg == TPSS_PS_DEEP) == $past(ctrl_reg[TPSS_DEEP_BIT]))
    else $error("deep sleep does not win power state");

  gain_decode_a: assert property (##1 active_gain == (4'h1 << $past(ctrl_reg[7:6])))
    else $error("active gain decode wrong");

  combo_gain_a: assert property ($past(ctrl_reg[TPSS_MIX_BIT]) |->
    standby_gain == (4'h1 << $past(ctrl_reg[3:2])))
    else $error("combo gain not used for standby inputs");

  recal_pulse_a: assert property (wr_ctrl && wr_data[7:6] != ctrl_reg[7:6] |=> recal_req)
    else $error("gain change did not request recalibration");

  deep_clear_a: assert property (ctrl_reg[TPSS_DEEP_BIT] |->
    tstat_reg == 8'h00 && gstat_reg == 8'h00 && alert_out_n)
    else $error("deep sleep left status or alert set");

  quiet_touch_a: assert property (quiet_touch_s |=> !ctrl_reg[TPSS_IRQ_BIT])
    else $error("disabled input raised the irq flag");

  irq_clear_a: assert property (int_clr && !irq_set |=>
    !ctrl_reg[TPSS_IRQ_BIT] && alert_out_n)
    else $error("irq clear did not release alert");

  set_wins_a: assert property (clr_and_set_s |=> ctrl_reg[TPSS_IRQ_BIT] ##0 !alert_out_n)
    else $error("event lost against host clear");

  // Sampled reset keeps the release edge itself out of the attempt
  boot_post_a: assert property (boot_reg && rst_n |=>
    gstat_reg[TPSS_GS_BOOT] && ctrl_reg[TPSS_IRQ_BIT])
    else $error("boot event missing");

  touch_sum_a: assert property (gstat_reg[TPSS_GS_TOUCH] == (|tstat_reg))
    else $error("touch summary bit wrong");

  keep_touch_a: assert property (int_clr && !deep_nx |=> tstat_reg == $past(tm))
    else $error("touch bits wrong after irq clear");

  release_once_a: assert property (rel_reg != 8'h00 |=> (rel_reg & $past(rel_reg)) == 8'h00)
    else $error("release reported twice");

  // Scan set, status and flag sources
  ctrl_write_a: assert property (wr_ctrl |=> ctrl_reg[7:1] == $past(wr_data[7:1]))
    else $error("control write lost");

  low_power_scan_en_write_a: assert property (wr_stb && reg_ptr == TPSS_ADDR_LOW_POWER_SCAN_EN |=>
    low_power_scan_en_reg == $past(wr_data))
    else $error("standby select write lost");

  low_power_scan_en_scan_a: assert property (ctrl_reg[5:4] == 2'b10 && !ctrl_reg[TPSS_MIX_BIT] |=>
    scan_mask == $past(low_power_scan_en_reg))
    else $error("standby scans wrong inputs");

  combo_scan_a: assert property (ctrl_reg[TPSS_MIX_BIT] && !ctrl_reg[TPSS_DEEP_BIT] |=>
    scan_mask == ($past(active_en) | $past(low_power_scan_en_reg)))
    else $error("combo scans wrong inputs");

  deep_scan_a: assert property (ctrl_reg[TPSS_DEEP_BIT] |=> scan_mask == 8'h00)
    else $error("deep sleep still scans");

  key_set_a: assert property (power_key_evt && !deep_nx |=>
    gstat_reg[TPSS_GS_PWR] && ctrl_reg[TPSS_IRQ_BIT])
    else $error("power key hold not posted");

  pat_gate_a: assert property (pattern_hit && !pattern_irq_en && !ctrl_reg[TPSS_IRQ_BIT]
    && (new_touch & irq_en) == 8'h00 && !power_key_evt && !boot_reg
    |=> !ctrl_reg[TPSS_IRQ_BIT])
    else $error("pattern raised irq while disabled");

  base_err_a: assert property ((|(base_err & mask_c)) && !deep_nx |=>
    gstat_reg[TPSS_GS_BC])
    else $error("base count error not flagged");

  cal_err_a: assert property ((|(cal_err & mask_c)) && !deep_nx |=>
    gstat_reg[TPSS_GS_CAL])
    else $error("calibration error not flagged");

  status_hold_a: assert property (!int_clr && !deep_nx |=>
    (tstat_reg & $past(tstat_reg)) == $past(tstat_reg))
    else $error("touch status dropped before clear");

  touch_set_a: assert property (!deep_nx |=> (tstat_reg & $past(tm)) == $past(tm))
    else $error("scanned touch not latched");
endmodule

/* inc/tpss_pkg.sv */
// Register map, field positions and state codes for the touch power and status block
// Summary of operation
// - Control at 00h: gain 7-6, standby 5, deep 4, combo gain 3-2, combo 1, irq 0.
// - Power state priority: deep sleep, then combo, then standby, else active.
// - Gain fields decode 00,01,10,11 to gains 1,2,4,8.
// - Combo clear: main gain for all; combo set: combo gain for standby inputs.
// - Any gain change requests recalibration of all inputs from scratch.
// - Standby scans standby inputs; status persists; dropped inputs report one release.
// - Combo scans active and standby inputs; status persists; dropped inputs report release.
// - Deep sleep stops scanning, clears all status and the irq flag.
// - Alert output is low whenever the irq flag is set.
// - Touch on input with interrupt disabled never sets the irq flag.
// - Host writes zero to clear irq; alert releases, stale status bits clear.
// - Touch status at 03h, input 8 in bit 7 to input 1 in bit 0.
// - Base count error bit 6 follows any enabled input out of limit.
// - Calibration error bit 5 follows any enabled input failing calibration.
// - Power key bit 4 sets irq; clears on irq clear if key released.
// - Boot bit 3 sets at reset exit with irq; clears with irq clear.
// - Multi-touch block bit 2 shows suppression and never sets irq.
// - Pattern bit 1 sets irq only if enabled; clears on irq clear once gone.
// - General status bit 0 is set while any touch status bit is set.
// - Touch bit clears on irq clear only if untouched; persisting touch gives no irq.
// - Power-on reset loads every register default.
// - Standby input selection register at 40h, default 00h.
package tpss_pkg;
  localparam logic [7:0] TPSS_ADDR_CTRL = 8'h00;
  localparam logic [7:0] TPSS_ADDR_GSTAT = 8'h02;
  localparam logic [7:0] TPSS_ADDR_TSTAT = 8'h03;
  localparam logic [7:0] TPSS_ADDR_LOW_POWER_SCAN_EN = 8'h40;
  localparam logic [7:0] TPSS_CTRL_RST = 8'h00;
  localparam logic [7:0] TPSS_GSTAT_RST = 8'h00;
  localparam logic [7:0] TPSS_TSTAT_RST = 8'h00;
  localparam logic [7:0] TPSS_LOW_POWER_SCAN_EN_RST = 8'h00;
  localparam int TPSS_GAIN_LSB = 6;
  localparam int TPSS_LPS_BIT = 5;
  localparam int TPSS_DEEP_BIT = 4;
  localparam int TPSS_CGAIN_LSB = 2;
  localparam int TPSS_MIX_BIT = 1;
  localparam int TPSS_IRQ_BIT = 0;
  localparam int TPSS_GS_BC = 6;
  localparam int TPSS_GS_CAL = 5;
  localparam int TPSS_GS_PWR = 4;
  localparam int TPSS_GS_BOOT = 3;
  localparam int TPSS_GS_MULTI_TOUCH_BLOCK = 2;
  localparam int TPSS_GS_PAT = 1;
  localparam int TPSS_GS_TOUCH = 0;
  localparam logic [3:0] TPSS_BITS_PER_BYTE = 4'h8;
  typedef enum logic [3:0] {
    TPSS_PS_ACTIVE = 4'b0001,
    TPSS_PS_STANDBY = 4'b0010,
    TPSS_PS_COMBO = 4'b0100,
    TPSS_PS_DEEP = 4'b1000
  } tpss_pstate_t;
  typedef enum logic [7:0] {
    TPSS_I2C_IDLE = 8'b00000001,
    TPSS_I2C_ADDR = 8'b00000010,
    TPSS_I2C_ACKA = 8'b00000100,
    TPSS_I2C_CMD = 8'b00001000,
    TPSS_I2C_ACKC = 8'b00010000,
    TPSS_I2C_WDAT = 8'b00100000,
    TPSS_I2C_ACKW = 8'b01000000,
    TPSS_I2C_RDAT = 8'b10000000
  } tpss_i2c_st_t;
endpackage

/* rtl/tpss_i2c_target.sv */
// Two-wire management bus target with register pointer and byte strobes
`timescale 1ns/1ps
module tpss_i2c_target #(
  parameter logic [6:0] DEV_ADDR = 7'h28
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe,
  // Register side
  output logic [7:0] reg_ptr,
  output logic wr_stb,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data
);
  import tpss_pkg::*;
  logic [2:0] scl_sy_reg;
  logic [2:0] sda_sy_reg;
  logic scl_rise, scl_fall, start_det, stop_det, sda_s;
  tpss_i2c_st_t st_reg, st_next;
  logic [7:0] sh_reg, sh_next, ptr_reg, ptr_next, wd_reg, wd_next;
  logic [3:0] cnt_reg, cnt_next;
  logic oe_reg, oe_next, ws_reg, ws_next, nack_reg, nack_next, rack_reg, rack_next;

  // Stage 0 feeds stage 1 only; edges are seen on stages 1 and 2
  assign sda_s = sda_sy_reg[1];
  assign scl_rise = scl_sy_reg[1] & ~scl_sy_reg[2];
  assign scl_fall = ~scl_sy_reg[1] & scl_sy_reg[2];
  assign start_det = scl_sy_reg[1] & scl_sy_reg[2] & ~sda_s & sda_sy_reg[2];
  assign stop_det = scl_sy_reg[1] & scl_sy_reg[2] & sda_s & ~sda_sy_reg[2];

  always_comb begin
    st_next = st_reg;
    sh_next = sh_reg;
    cnt_next = cnt_reg;
    oe_next = oe_reg;
    ptr_next = ptr_reg;
    ws_next = 1'b0;
    wd_next = wd_reg;
    nack_next = nack_reg;
    rack_next = rack_reg;
    if (start_det) begin
      st_next = TPSS_I2C_ADDR;
      cnt_next = 4'h0;
      oe_next = 1'b0;
    end else if (stop_det) begin
      st_next = TPSS_I2C_IDLE;
      oe_next = 1'b0;
    end else begin
      case (st_reg)
        TPSS_I2C_ADDR, TPSS_I2C_CMD, TPSS_I2C_WDAT: begin
          if (scl_rise) begin
            sh_next = {sh_reg[6:0], sda_s};
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == TPSS_BITS_PER_BYTE) begin
            cnt_next = 4'h0;
            oe_next = 1'b1;
            if (st_reg == TPSS_I2C_ADDR) begin
              if (sh_reg[7:1] == DEV_ADDR) begin
                st_next = TPSS_I2C_ACKA;
              end else begin
                st_next = TPSS_I2C_IDLE;
                oe_next = 1'b0;
              end
            end else if (st_reg == TPSS_I2C_CMD) begin
              ptr_next = sh_reg;
              st_next = TPSS_I2C_ACKC;
            end else begin
              ws_next = 1'b1;
              wd_next = sh_reg;
              st_next = TPSS_I2C_ACKW;
            end
          end
        end
        TPSS_I2C_ACKA: begin
          if (scl_fall && sh_reg[0]) begin
            st_next = TPSS_I2C_RDAT;
            sh_next = rd_data;
            oe_next = ~rd_data[7];
            rack_next = 1'b0;
          end else if (scl_fall) begin
            st_next = TPSS_I2C_CMD;
            oe_next = 1'b0;
          end
        end
        TPSS_I2C_ACKC, TPSS_I2C_ACKW: begin
          if (scl_fall) begin
            st_next = TPSS_I2C_WDAT;
            oe_next = 1'b0;
            if (st_reg == TPSS_I2C_ACKW) begin
              ptr_next = ptr_reg + 8'h01;
            end
          end
        end
        TPSS_I2C_RDAT: begin
          // Read data bits, then the controller's acknowledge slot
          if (scl_rise && rack_reg) begin
            nack_next = sda_s;
            if (!sda_s) begin
              ptr_next = ptr_reg + 8'h01;
            end
          end else if (scl_rise) begin
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall && rack_reg) begin
            rack_next = 1'b0;
            cnt_next = 4'h0;
            if (nack_reg) begin
              st_next = TPSS_I2C_IDLE;
            end else begin
              sh_next = rd_data;
              oe_next = ~rd_data[7];
            end
          end else if (scl_fall && cnt_reg == TPSS_BITS_PER_BYTE) begin
            oe_next = 1'b0;
            rack_next = 1'b1;
          end else if (scl_fall) begin
            sh_next = {sh_reg[6:0], 1'b0};
            oe_next = ~sh_reg[6];
          end
        end
        TPSS_I2C_IDLE: begin
          oe_next = 1'b0;
        end
        default: begin
          st_next = TPSS_I2C_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sy_reg <= 3'h7;
      sda_sy_reg <= 3'h7;
      st_reg <= TPSS_I2C_IDLE;
      sh_reg <= 8'h00;
      cnt_reg <= 4'h0;
      oe_reg <= 1'b0;
      ptr_reg <= 8'h00;
      ws_reg <= 1'b0;
      wd_reg <= 8'h00;
      nack_reg <= 1'b0;
      rack_reg <= 1'b0;
    end else begin
      scl_sy_reg <= {scl_sy_reg[1:0], scl_in};
      sda_sy_reg <= {sda_sy_reg[1:0], sda_in};
      st_reg <= st_next;
      sh_reg <= sh_next;
      cnt_reg <= cnt_next;
      oe_reg <= oe_next;
      ptr_reg <= ptr_next;
      ws_reg <= ws_next;
      wd_reg <= wd_next;
      nack_reg <= nack_next;
      rack_reg <= rack_next;
    end
  end

  assign sda_oe = oe_reg;
  assign reg_ptr = ptr_reg;
  assign wr_stb = ws_reg;
  assign wr_data = wd_reg;
endmodule

/* verification/tpss_host_model.sv */
// Host side bus master model for the two-wire management bus
`timescale 1ns/1ps
module tpss_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h28
) (
  // Clock
  input wire logic core_clk,
  // Bus, open drain with pull-up on the wire
  output logic scl,
  output logic sda_pull,
  input wire logic sda,
  // Read result strobe
  output logic rd_valid,
  output logic [7:0] rd_byte
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    rd_valid = 1'b0;
    rd_byte = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Eight cycles per phase, twice the minimum the target needs
  task automatic bit_io(input logic b, output logic s);
    sda_pull <= ~b;
    tick(8);
    scl <= 1'b1;
    tick(4);
    s = sda;
    tick(4);
    scl <= 1'b0;
    tick(1);
  endtask
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
      q[i] = s;
    end
    // Ninth slot released: target acks, or host nacks a read
    bit_io(1'b1, s);
  endtask
  task automatic start;
    sda_pull <= 1'b0;
    tick(8);
    scl <= 1'b1;
    tick(8);
    sda_pull <= 1'b1;
    tick(8);
    scl <= 1'b0;
    tick(4);
  endtask
  task automatic stop;
    sda_pull <= 1'b1;
    tick(8);
    scl <= 1'b1;
    tick(8);
    sda_pull <= 1'b0;
    tick(8);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    start();
    byte_io({DEV_ADDR, 1'b0}, q);
    byte_io(a, q);
    byte_io(d, q);
    stop();
  endtask
  task automatic rd_reg(input logic [7:0] a);
    logic [7:0] q;
    start();
    byte_io({DEV_ADDR, 1'b0}, q);
    byte_io(a, q);
    start();
    byte_io({DEV_ADDR, 1'b1}, q);
    byte_io(8'hff, q);
    stop();
    rd_byte <= q;
    rd_valid <= 1'b1;
    tick(1);
    rd_valid <= 1'b0;
  endtask
endmodule

/* verification/test_touch_power_state_and_status.sv */
// Self-checking bench for the touch power state and status block
`timescale 1ns/1ps
module test_touch_power_state_and_status;
  import tpss_pkg::*;
  logic core_clk, rst_n, scl, host_pull, sda_line, sda_out, sda_oe;
  logic [7:0] touch_now, active_en, irq_en, base_err, cal_err, scan_mask, release_evt, rd_byte;
  logic power_key_evt, power_key_touch, multi_block, pattern_hit, pattern_irq_en;
  logic alert_out_n, recal_req, rd_valid;
  logic [3:0] active_gain, standby_gain;
  tpss_pstate_t power_state;
  logic [31:0] seed = 32'h848a1a3a;
  logic [7:0] exp_q[$];
  int failures = 0;
  int checked = 0;
  int recal_cnt = 0;
  int rel_cnt = 0;
  // Pull-up wins unless someone pulls low
  assign sda_line = (sda_oe ? sda_out : 1'b1) & ~host_pull;
  tpss_core dut_u (.core_clk(core_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .touch_now(touch_now), .active_en(active_en),
    .irq_en(irq_en), .base_err(base_err), .cal_err(cal_err), .power_key_evt(power_key_evt),
    .power_key_touch(power_key_touch), .multi_block(multi_block), .pattern_hit(pattern_hit),
    .pattern_irq_en(pattern_irq_en), .alert_out_n(alert_out_n), .power_state(power_state),
    .scan_mask(scan_mask), .active_gain(active_gain), .standby_gain(standby_gain),
    .recal_req(recal_req), .release_evt(release_evt));
  tpss_host_model host_u (.core_clk(core_clk), .scl(scl), .sda_pull(host_pull),
    .sda(sda_line), .rd_valid(rd_valid), .rd_byte(rd_byte));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic cmp8(input string w, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic flag(input string w, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %b seen %b", w, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_u.rd_reg(a);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.wr_reg(a, d);
  endtask
  task automatic settle;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic test_done;
    $display("Comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    if (rd_valid === 1'b1 && exp_q.size() > 0) begin
      cmp8("read byte", exp_q.pop_front(), rd_byte);
    end
    if (recal_req === 1'b1) begin
      recal_cnt++;
    end
    if (release_evt[1] === 1'b1) begin
      rel_cnt++;
    end
  end
  // Whole run is about 37k cycles
  initial begin
    #400us;
    failures++;
    test_done();
  end
  initial begin
    tpss_pstate_t e;
    logic [7:0] v;
    int n;
    rst_n = 1'b0;
    touch_now = 8'h00;
    active_en = 8'h0f;
    irq_en = 8'hff;
    base_err = 8'h00;
    cal_err = 8'h00;
    power_key_evt = 1'b0;
    power_key_touch = 1'b0;
    multi_block = 1'b0;
    pattern_hit = 1'b0;
    pattern_irq_en = 1'b0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    flag("alert", 1'b0, alert_out_n);
    rd(TPSS_ADDR_CTRL, 8'h01);
    rd(TPSS_ADDR_GSTAT, 8'h08);
    rd(TPSS_ADDR_TSTAT, TPSS_TSTAT_RST);
    rd(TPSS_ADDR_LOW_POWER_SCAN_EN, TPSS_LOW_POWER_SCAN_EN_RST);
    rd(8'h10, 8'h00);
    wr(TPSS_ADDR_CTRL, 8'h01);
    flag("alert", 1'b0, alert_out_n);
    wr(TPSS_ADDR_CTRL, 8'h00);
    flag("alert", 1'b1, alert_out_n);
    rd(TPSS_ADDR_GSTAT, 8'h00);
    $display("reset and clear test done");
    for (int k = 0; k < 8; k++) begin
      v = {2'b00, k[0], k[1], 2'b00, k[2], 1'b0};
      e = k[1] ? TPSS_PS_DEEP : (k[2] ? TPSS_PS_COMBO :
        (k[0] ? TPSS_PS_STANDBY : TPSS_PS_ACTIVE));
      wr(TPSS_ADDR_CTRL, v);
      cmp8("state", {4'h0, e}, {4'h0, power_state});
      rd(TPSS_ADDR_CTRL, v);
    end
    wr(TPSS_ADDR_CTRL, 8'h00);
    $display("power state test done");
    for (int g = 0; g < 4; g++) begin
      v = {g[1:0], 2'b00, ~g[1:0], g[0], 1'b0};
      n = recal_cnt;
      wr(TPSS_ADDR_CTRL, v);
      cmp8("recal", 8'(n + 1), 8'(recal_cnt));
      cmp8("active gain", 8'(1 << g), {4'h0, active_gain});
      cmp8("standby gain", g[0] ? 8'(1 << (3 - g)) : 8'(1 << g), {4'h0, standby_gain});
    end
    wr(TPSS_ADDR_CTRL, 8'h00);
    $display("gain test done");
    seed = xs(seed);
    wr(TPSS_ADDR_LOW_POWER_SCAN_EN, seed[7:0]);
    rd(TPSS_ADDR_LOW_POWER_SCAN_EN, seed[7:0]);
    wr(TPSS_ADDR_LOW_POWER_SCAN_EN, 8'h01);
    @(posedge core_clk) touch_now <= 8'h02;
    settle();
    flag("alert", 1'b0, alert_out_n);
    rd(TPSS_ADDR_TSTAT, 8'h02);
    rd(TPSS_ADDR_GSTAT, 8'h01);
    n = rel_cnt;
    wr(TPSS_ADDR_CTRL, 8'h20);
    cmp8("release", 8'(n + 1), 8'(rel_cnt));
    cmp8("scan", 8'h01, scan_mask);
    wr(TPSS_ADDR_CTRL, 8'h02);
    cmp8("scan", 8'h0f, scan_mask);
    @(posedge core_clk) touch_now <= 8'h01;
    settle();
    wr(TPSS_ADDR_CTRL, 8'h00);
    flag("alert", 1'b1, alert_out_n);
    rd(TPSS_ADDR_TSTAT, 8'h01);
    @(posedge core_clk) touch_now <= 8'h00;
    wr(TPSS_ADDR_CTRL, 8'h00);
    rd(TPSS_ADDR_TSTAT, 8'h00);
    @(posedge core_clk) irq_en <= 8'hfb;
    @(posedge core_clk) touch_now <= 8'h04;
    settle();
    flag("alert", 1'b1, alert_out_n);
    rd(TPSS_ADDR_TSTAT, 8'h04);
    @(posedge core_clk) touch_now <= 8'h00;
    irq_en <= 8'hff;
    wr(TPSS_ADDR_CTRL, 8'h00);
    $display("scan and touch test done");
    @(posedge core_clk) multi_block <= 1'b1;
    rd(TPSS_ADDR_GSTAT, 8'h04);
    flag("alert", 1'b1, alert_out_n);
    @(posedge core_clk) multi_block <= 1'b0;
    wr(TPSS_ADDR_CTRL, 8'h00);
    @(posedge core_clk) pattern_hit <= 1'b1;
    rd(TPSS_ADDR_GSTAT, 8'h02);
    flag("alert", 1'b1, alert_out_n);
    @(posedge core_clk) pattern_hit <= 1'b0;
    wr(TPSS_ADDR_CTRL, 8'h00);
    rd(TPSS_ADDR_GSTAT, 8'h00);
    @(posedge core_clk) pattern_irq_en <= 1'b1;
    @(posedge core_clk) pattern_hit <= 1'b1;
    settle();
    flag("alert", 1'b0, alert_out_n);
    @(posedge core_clk) pattern_hit <= 1'b0;
    wr(TPSS_ADDR_CTRL, 8'h00);
    @(posedge core_clk) power_key_touch <= 1'b1;
    power_key_evt <= 1'b1;
    @(posedge core_clk) power_key_evt <= 1'b0;
    settle();
    flag("alert", 1'b0, alert_out_n);
    wr(TPSS_ADDR_CTRL, 8'h00);
    rd(TPSS_ADDR_GSTAT, 8'h10);
    @(posedge core_clk) power_key_touch <= 1'b0;
    wr(TPSS_ADDR_CTRL, 8'h00);
    rd(TPSS_ADDR_GSTAT, 8'h00);
    @(posedge core_clk) base_err <= 8'h81;
    cal_err <= 8'h02;
    rd(TPSS_ADDR_GSTAT, 8'h60);
    @(posedge core_clk) base_err <= 8'h80;
    rd(TPSS_ADDR_GSTAT, 8'h20);
    @(posedge core_clk) cal_err <= 8'h00;
    rd(TPSS_ADDR_GSTAT, 8'h00);
    @(posedge core_clk) base_err <= 8'h00;
    wr(TPSS_ADDR_CTRL, 8'h00);
    $display("general status test done");
    // Touch rising every cycle makes the clear strobe meet a set
    fork
      wr(TPSS_ADDR_CTRL, 8'h00);
      repeat (600) @(posedge core_clk) touch_now <= (touch_now == 8'h01) ? 8'h02 : 8'h01;
    join
    flag("alert", 1'b0, alert_out_n);
    // Held touch tells deep sleep apart from a plain flag clear
    @(posedge core_clk) touch_now <= 8'h01;
    settle();
    wr(TPSS_ADDR_CTRL, 8'h10);
    flag("alert", 1'b1, alert_out_n);
    cmp8("scan", 8'h00, scan_mask);
    rd(TPSS_ADDR_TSTAT, 8'h00);
    rd(TPSS_ADDR_GSTAT, 8'h00);
    @(posedge core_clk) touch_now <= 8'h00;
    wr(TPSS_ADDR_CTRL, 8'h00);
    $display("deep sleep test done");
    repeat (4) @(posedge core_clk);
    cmp8("pending reads", 8'h00, 8'(exp_q.size()));
    test_done();
  end
endmodule
